/* File: verilog/actuator_regs.vh */
// Notes on behaviour
// R1 - Mode press advances function, lights its indicator
// R2 - Selected indicator steady, except manual centering and auto under comms
// R3 - Zero-based 5V/10V spans skip loss function
// R4 - Adjust buttons act on selected function only
// R5 - Override above threshold disables buttons, manual lit
// R6 - Override released resumes previously selected mode
// R7 - Override operation decoded from input resistance
// R8 - Open/close drive in learned setpoint directions
// R9 - Latch keeps previous open or close running
// R10 - Off and stop halt motor, clear latch
// R11 - Override movement stops at stored position
// R12 - Feedback fault: timed run, ended by off/stop
// R13 - Stall stops motor; retry after off/latch/stop
// R14 - Trip blocks that direction; opposite move clears
// R15 - Double trip cleared by manual mode only
// R16 - External command ignored outside automatic mode
// R17 - Minimum command closed, full scale open
// R18 - Comms may override; auto indicator flashes then
// R19 - Manual up drives motor1 high, down reverses
// R20 - Manual indicator flash slows away from midrange
// R21 - Closed function seeks, adjusts, stores on press
// R22 - Open function behaves like closed function
// R23 - Motor off ties both terminals to negative
// R24 - Auto target interpolated between setpoints linearly
// R25 - Buttons debounced, acted on once per press
`ifndef ACTUATOR_REGS_VH
`define ACTUATOR_REGS_VH

`define MODE_MANUAL 3'h0
`define MODE_CLOSE 3'h1
`define MODE_OPEN 3'h2
`define MODE_LOSS 3'h3
`define MODE_AUTO 3'h4

`define OP_NONE 3'h0
`define OP_OFF 3'h1
`define OP_LATCH 3'h2
`define OP_OPEN 3'h3
`define OP_CLOSE 3'h4
`define OP_STOP 3'h5

`define RUN_IDLE 2'h0
`define RUN_OPEN 2'h1
`define RUN_CLOSE 2'h2

`define OHM_SHORT_MAX 14'h00FA
`define OHM_OFF_MIN 14'h10CC
`define OHM_LATCH_LO 14'h0C3F
`define OHM_LATCH_HI 14'h0D89
`define OHM_OPEN_LO 14'h076C
`define OHM_OPEN_HI 14'h0834
`define OHM_CLOSE_LO 14'h0474
`define OHM_CLOSE_HI 14'h04EC
`define OHM_STOP_LO 14'h01E5
`define OHM_STOP_HI 14'h0217

`define CT_ZERO_5V 3'h2
`define CT_ZERO_10V 3'h3

`define LD_LAST 2'h0
`define LD_OPEN 2'h1
`define LD_CLOSE 2'h2

`define POT_MID 10'h200
`define MID_BAND 10'h008
`define SEEK_BAND 10'h004
`define TRIP_CLEAR_MOVE 10'h010
`define CLOSED_SP_RST 10'h040
`define OPEN_SP_RST 10'h3C0
`define FLASH_BIT 5'h15

// 10 ms debounce and 15 minute fault run at 20 MHz
`define DEBOUNCE_CYC 18'h30D40
`define FB_RUN_CYC_DEF 36'h430E23400

`endif

/* File: verilog/actuator_mode_and_override_control.v */
`timescale 1ns/1ns
`default_nettype none
`include "actuator_regs.vh"

module actuator_mode_and_override_control #(
  parameter [17:0] DEB_CYC = `DEBOUNCE_CYC,
  parameter [35:0] FB_RUN_CYC = `FB_RUN_CYC_DEF
) (
  // Clock and reset
  input wire sys_clk,
  input wire resetn,
  // Front-panel buttons, high while pressed
  input wire btn_mode,
  input wire btn_up,
  input wire btn_down,
  // Override input resistance in ohms
  input wire [13:0] ovr_ohms,
  // Command configuration and levels, 0 = span minimum
  input wire [2:0] cmd_type,
  input wire [9:0] cmd_level,
  input wire comm_active,
  input wire [9:0] comm_level,
  // Actuator feedback and protection events
  input wire [9:0] position,
  input wire fb_fault,
  input wire stall,
  input wire current_trip,
  // Motor drive; low means tied to supply_negative
  output reg motor1_high,
  output reg motor2_high,
  // Indicators
  output reg led_manual,
  output reg led_close,
  output reg led_open,
  output reg led_loss,
  output reg led_auto,
  // State
  output reg [2:0] mode,
  output reg override_on,
  output reg [9:0] closed_sp,
  output reg [9:0] open_sp,
  output reg [1:0] loss_default
);

  function [2:0] decode_ovr;
    input [13:0] r;
    begin
      if (r <= `OHM_SHORT_MAX)
        decode_ovr = `OP_NONE;
      else if (r >= `OHM_STOP_LO && r <= `OHM_STOP_HI)
        decode_ovr = `OP_STOP;
      else if (r >= `OHM_CLOSE_LO && r <= `OHM_CLOSE_HI)
        decode_ovr = `OP_CLOSE;
      else if (r >= `OHM_OPEN_LO && r <= `OHM_OPEN_HI)
        decode_ovr = `OP_OPEN;
      else if (r >= `OHM_LATCH_LO && r <= `OHM_LATCH_HI)
        decode_ovr = `OP_LATCH;
      else
        decode_ovr = `OP_OFF; // Between bands or above 4.3K: safest is off
    end
  endfunction

  function [9:0] distance;
    input [9:0] a;
    input [9:0] b;
    begin
      distance = (a > b) ? a - b : b - a;
    end
  endfunction

  function [1:0] seek;
    input [9:0] tgt;
    input [9:0] pos;
    begin
      if ({1'b0, pos} + {1'b0, `SEEK_BAND} < {1'b0, tgt})
        seek = 2'b10;
      else if ({1'b0, tgt} + {1'b0, `SEEK_BAND} < {1'b0, pos})
        seek = 2'b01;
      else
        seek = 2'b00;
    end
  endfunction

  function [2:0] advance;
    input [2:0] m;
    input [2:0] ct;
    begin
      case (m)
        `MODE_MANUAL: advance = `MODE_CLOSE;
        `MODE_CLOSE: advance = `MODE_OPEN;
        `MODE_OPEN: advance = (ct == `CT_ZERO_5V || ct == `CT_ZERO_10V) ?
                              `MODE_AUTO : `MODE_LOSS; // [R3]
        `MODE_LOSS: advance = `MODE_AUTO;
        default: advance = `MODE_MANUAL;
      endcase
    end
  endfunction

  // Debounce: a level counts only when two samples a period apart agree
  reg [17:0] deb_cnt;
  reg [2:0] samp;
  reg [2:0] btn_lvl;
  reg [2:0] btn_prev;
  reg [25:0] blink_cnt;
  wire [2:0] raw = {btn_down, btn_up, btn_mode};
  wire deb_tick = (deb_cnt == DEB_CYC - 18'h00001);
  wire [2:0] press = btn_lvl & ~btn_prev; // [R25]

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      deb_cnt <= 18'h00000;
      samp <= 3'h0;
      btn_lvl <= 3'h0;
      btn_prev <= 3'h0;
      blink_cnt <= 26'h0000000;
    end else begin
      deb_cnt <= deb_tick ? 18'h00000 : deb_cnt + 18'h00001;
      blink_cnt <= blink_cnt + 26'h0000001;
      btn_prev <= btn_lvl;
      if (deb_tick) begin
        samp <= raw;
        btn_lvl <= (samp & raw) | (btn_lvl & (samp ^ raw)); // [R25]
      end
    end
  end

  wire [2:0] op = decode_ovr(ovr_ohms); // [R7]
  wire ovr = (op != `OP_NONE); // [R5]
  wire open_up = (open_sp >= closed_sp);
  wire [1:0] open_drive = open_up ? 2'b10 : 2'b01; // [R8]
  wire [1:0] close_drive = open_up ? 2'b01 : 2'b10; // [R8]
  wire at_open = open_up ? (position >= open_sp) : (position <= open_sp);
  wire at_closed = open_up ? (position <= closed_sp) : (position >= closed_sp);

  reg [1:0] run;
  reg stall_lock;
  reg blk_open;
  reg blk_close;
  reg dbl_trip;
  reg [9:0] trip_ref;
  reg [35:0] fb_timer;
  reg seeking;

  // Automatic target: comms wins over the analog command when active
  wire [9:0] auto_cmd = comm_active ? comm_level : cmd_level; // [R18]
  wire signed [10:0] sp_span = $signed({1'b0, open_sp}) - $signed({1'b0, closed_sp});
  wire signed [21:0] sp_prod = sp_span * $signed({1'b0, auto_cmd});
  wire signed [21:0] sp_sum = sp_prod + $signed({2'b00, closed_sp, 10'h000});
  // With open above closed, full scale of 3FF lands one step short of open, inside the seek band
  wire [9:0] auto_tgt = sp_sum[19:10]; // [R17] [R24]

  wire start_open = (op == `OP_OPEN) && !stall_lock && !blk_open &&
                    (fb_fault || !at_open);
  wire start_close = (op == `OP_CLOSE) && !stall_lock && !blk_close &&
                     (fb_fault || !at_closed);
  wire moved_back = distance(position, trip_ref) >= `TRIP_CLEAR_MOVE;
  wire panel_manual = !ovr && mode == `MODE_MANUAL && (btn_lvl[1] || btn_lvl[2]);

  // Override movement sequencer
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      run <= `RUN_IDLE;
      stall_lock <= 1'b0;
      blk_open <= 1'b0;
      blk_close <= 1'b0;
      dbl_trip <= 1'b0;
      trip_ref <= 10'h000;
      fb_timer <= 36'h000000000;
    end else begin
      if (op == `OP_OFF || op == `OP_LATCH || op == `OP_STOP)
        stall_lock <= 1'b0; // [R13]
      if (!ovr || op == `OP_OFF || op == `OP_STOP) begin
        run <= `RUN_IDLE; // [R10]
      end else if (start_open && run != `RUN_OPEN) begin
        run <= `RUN_OPEN;
        fb_timer <= FB_RUN_CYC;
      end else if (start_close && run != `RUN_CLOSE) begin
        run <= `RUN_CLOSE;
        fb_timer <= FB_RUN_CYC;
      end else if (run != `RUN_IDLE) begin
        // Latch and a held open/close both keep the movement going [R9]
        if (fb_fault) begin
          fb_timer <= fb_timer - 36'h000000001;
          if (fb_timer <= 36'h000000001) begin
            run <= `RUN_IDLE; // [R12]
            stall_lock <= 1'b1;
          end
        end else if ((run == `RUN_OPEN && at_open) ||
                     (run == `RUN_CLOSE && at_closed)) begin
          run <= `RUN_IDLE; // [R11]
        end
        if (run == `RUN_CLOSE && blk_open && !dbl_trip && moved_back)
          blk_open <= 1'b0; // [R14]
        if (run == `RUN_OPEN && blk_close && !dbl_trip && moved_back)
          blk_close <= 1'b0; // [R14]
      end
      if (ovr && run != `RUN_IDLE && current_trip) begin
        run <= `RUN_IDLE;
        trip_ref <= position;
        if (run == `RUN_OPEN)
          blk_open <= 1'b1; // [R14]
        else
          blk_close <= 1'b1; // [R14]
        if ((run == `RUN_OPEN && blk_close) || (run == `RUN_CLOSE && blk_open))
          dbl_trip <= 1'b1; // [R15]
      end else if (ovr && run != `RUN_IDLE && stall) begin
        run <= `RUN_IDLE; // [R13]
        stall_lock <= 1'b1; // [R13]
      end else if (panel_manual) begin
        blk_open <= 1'b0; // [R15]
        blk_close <= 1'b0;
        dbl_trip <= 1'b0;
      end
    end
  end

  // Mode sequencer and setpoints; mode is frozen during override [R6]
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mode <= `MODE_MANUAL;
      override_on <= 1'b0;
      closed_sp <= `CLOSED_SP_RST;
      open_sp <= `OPEN_SP_RST;
      loss_default <= `LD_LAST;
      seeking <= 1'b0;
    end else begin
      override_on <= ovr;
      if (!ovr) begin // [R5]
        if (press[0]) begin
          mode <= advance(mode, cmd_type); // [R1] [R3]
          seeking <= 1'b1; // [R21] [R22]
          if (mode == `MODE_CLOSE)
            closed_sp <= position; // [R21]
          if (mode == `MODE_OPEN)
            open_sp <= position; // [R22]
        end else if (mode == `MODE_LOSS) begin // [R4]
          if (press[1])
            loss_default <= (loss_default == `LD_CLOSE) ? `LD_LAST : loss_default + 2'h1;
          else if (press[2])
            loss_default <= (loss_default == `LD_LAST) ? `LD_CLOSE : loss_default - 2'h1;
        end else if (btn_lvl[1] || btn_lvl[2]) begin
          seeking <= 1'b0; // [R21]
        end
      end
    end
  end

  // Motor drive choice
  reg [1:0] next_drive;
  always @* begin
    next_drive = 2'b00; // [R23]
    if (ovr) begin
      if (run == `RUN_OPEN)
        next_drive = open_drive; // [R8]
      else if (run == `RUN_CLOSE)
        next_drive = close_drive; // [R8]
    end else begin
      case (mode)
        `MODE_MANUAL: begin
          if (btn_lvl[1])
            next_drive = 2'b10; // [R19]
          else if (btn_lvl[2])
            next_drive = 2'b01; // [R19]
        end
        `MODE_CLOSE, `MODE_OPEN: begin
          if (btn_lvl[1])
            next_drive = 2'b10; // [R4]
          else if (btn_lvl[2])
            next_drive = 2'b01;
          else if (seeking)
            next_drive = seek((mode == `MODE_CLOSE) ? closed_sp : open_sp,
                              position); // [R21] [R22]
        end
        `MODE_AUTO: next_drive = seek(auto_tgt, position); // [R16] [R17]
        default: next_drive = 2'b00;
      endcase
    end
  end

  // Flash rate slows one octave per distance step from midrange
  wire [9:0] mid_dist = distance(position, `POT_MID);
  wire [4:0] flash_sel = `FLASH_BIT + {2'b00, mid_dist[9:7]};
  wire centre_flash = (mid_dist < `MID_BAND) | blink_cnt[flash_sel]; // [R20]
  wire blink = blink_cnt[`FLASH_BIT];

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      motor1_high <= 1'b0;
      motor2_high <= 1'b0;
      led_manual <= 1'b0;
      led_close <= 1'b0;
      led_open <= 1'b0;
      led_loss <= 1'b0;
      led_auto <= 1'b0;
    end else begin
      motor1_high <= next_drive[1];
      motor2_high <= next_drive[0];
      led_manual <= ovr | (mode == `MODE_MANUAL & centre_flash); // [R5] [R20]
      led_close <= !ovr && (mode == `MODE_CLOSE ||
                   (mode == `MODE_LOSS && loss_default == `LD_CLOSE && blink)); // [R2]
      led_open <= !ovr && (mode == `MODE_OPEN ||
                  (mode == `MODE_LOSS && loss_default == `LD_OPEN && blink)); // [R2]
      led_loss <= !ovr && mode == `MODE_LOSS; // [R1]
      led_auto <= !ovr && mode == `MODE_AUTO && (!comm_active || blink); // [R18]
    end
  end

endmodule
`default_nettype wire

/* File: bench/actuator_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module actuator_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Inputs
  input wire logic [13:0] ovr_ohms,
  input wire logic [2:0] cmd_type,
  // Outputs
  input wire logic motor1_high,
  input wire logic motor2_high,
  input wire logic led_manual,
  input wire logic [2:0] mode,
  input wire logic override_on
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  logic halt_op;
  // Off band or stop band
  assign halt_op = ovr_ohms >= 14'h10CC || (ovr_ohms >= 14'h01E5 && ovr_ohms <= 14'h0217);
  a_no_shoot_through: assert property (!(motor1_high && motor2_high))
    else $error("motor terminals both high");
  a_override_tracks: assert property (
    $past(resetn) |-> override_on == ($past(ovr_ohms) > 14'h00FA))
    else $error("override flag wrong");
  a_override_led: assert property (override_on [*3] |-> led_manual)
    else $error("manual led dark in override");
  a_mode_frozen: assert property (override_on && $past(override_on) |-> $stable(mode))
    else $error("mode moved in override");
  a_mode_legal: assert property (mode <= 3'h4)
    else $error("mode out of range");
  a_mode_step: assert property (
    $past(resetn) && $changed(mode) && $past(mode) != 3'h2
    |-> mode == ($past(mode) == 3'h4 ? 3'h0 : $past(mode) + 3'h1))
    else $error("mode step wrong");
  a_open_next: assert property (
    $past(resetn) && $changed(mode) && $past(mode) == 3'h2
    |-> mode == ($past(cmd_type) inside {3'h2, 3'h3} ? 3'h4 : 3'h3))
    else $error("mode after open wrong");
  a_halt_motor_off: assert property (halt_op [*3] |=> !motor1_high && !motor2_high)
    else $error("motor runs on off or stop");
endmodule
bind actuator_mode_and_override_control actuator_checker u_chk (
  .sys_clk, .resetn, .ovr_ohms, .cmd_type, .motor1_high,
  .motor2_high, .led_manual, .mode, .override_on);
`default_nettype wire

/* File: bench/motor_model.sv */
`timescale 1ns/1ns
`default_nettype none
module motor_model (
  // Clock and drive
  input wire logic sys_clk,
  input wire logic motor1_high,
  input wire logic motor2_high,
  // Pot wiper
  output logic [9:0] position
);
  initial position = 10'h200;
  // One count per clock keeps seeks short; both low brakes
  always @(posedge sys_clk) begin
    if (motor1_high && !motor2_high && position != 10'h3FF) begin
      position <= position + 10'h001;
    end else if (motor2_high && !motor1_high && position != 10'h000) begin
      position <= position - 10'h001;
    end
  end
endmodule
`default_nettype wire

/* File: bench/actuator_mode_and_override_control_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module actuator_mode_and_override_control_tb;
  logic sys_clk, resetn, btn_mode, btn_up, btn_down, comm_active, stall, fb_fault, current_trip;
  logic [13:0] ovr_ohms;
  logic [2:0] cmd_type, mode;
  logic [9:0] cmd_level, comm_level, position, closed_sp, open_sp, cs, os;
  logic motor1_high, motor2_high, led_manual, led_close, led_open, led_loss, led_auto;
  logic override_on;
  logic [1:0] loss_default;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  actuator_mode_and_override_control #(.DEB_CYC(18'h00004), .FB_RUN_CYC(36'h000000032)) uut (
    .sys_clk(sys_clk), .resetn(resetn), .btn_mode(btn_mode), .btn_up(btn_up),
    .btn_down(btn_down), .ovr_ohms(ovr_ohms), .cmd_type(cmd_type), .cmd_level(cmd_level),
    .comm_active(comm_active), .comm_level(comm_level), .position(position),
    .fb_fault(fb_fault), .stall(stall), .current_trip(current_trip), .motor1_high(motor1_high),
    .motor2_high(motor2_high), .led_manual(led_manual), .led_close(led_close),
    .led_open(led_open), .led_loss(led_loss), .led_auto(led_auto), .mode(mode),
    .override_on(override_on), .closed_sp(closed_sp), .open_sp(open_sp),
    .loss_default(loss_default));
  motor_model pm (.sys_clk(sys_clk), .motor1_high(motor1_high),
    .motor2_high(motor2_high), .position(position));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task summarize;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task near(input logic [9:0] a, input logic [9:0] b, input string what);
    check({15'h0000, (a > b ? a - b : b - a) <= 10'h006}, 16'h0001, what);
  endtask
  task drive(input logic [1:0] e, input string what);
    check({14'h0000, motor1_high, motor2_high}, {14'h0000, e}, what);
  endtask
  // Held well past two debounce samples, so one press only
  task tap(input int up);
    if (up != 0) btn_up = 1'b1;
    else btn_mode = 1'b1;
    tick(20);
    btn_mode = 1'b0;
    btn_up = 1'b0;
    tick(20);
  endtask
  function logic [9:0] tgt(input logic [9:0] c);
    tgt = cs + 10'((20'(os - cs) * 20'(c)) >> 10);
  endfunction
  task t_reset;
    check(16'(mode), 16'h0000, "mode");
    check(16'(closed_sp), 16'h0040, "closed_sp");
    check(16'(open_sp), 16'h03C0, "open_sp");
    drive(2'h0, "motor");
  endtask
  task t_manual;
    tick(20);
    drive(2'h0, "cmd ignored");
    check(16'(led_manual), 16'h0001, "midrange led");
    btn_up = 1'b1;
    tick(20);
    drive(2'h2, "up");
    check(16'(led_manual), 16'h0000, "off-mid led");
    btn_up = 1'b0;
    btn_down = 1'b1;
    tick(20);
    drive(2'h1, "down");
    btn_down = 1'b0;
    // Release needs two debounce samples plus the output register
    tick(12);
    drive(2'h0, "brake");
    check(16'(closed_sp), 16'h0040, "closed_sp kept");
  endtask
  task t_setup;
    tap(0);
    check(16'({mode, led_manual, led_close}), 16'h0005, "close sel");
    tick(1000);
    near(position, 10'h040, "seek closed");
    cs = position;
    tap(0);
    check(16'(closed_sp), 16'(cs), "closed store");
    check(16'({mode, led_open}), 16'h0005, "open sel");
    tick(1000);
    near(position, 10'h3C0, "seek open");
    os = position;
    tap(0);
    check(16'(open_sp), 16'(os), "open store");
    check(16'(mode), 16'h0003, "loss sel");
    check(16'(led_loss), 16'h0001, "loss led");
    tap(1);
    check(16'(loss_default), 16'h0001, "loss up");
    tap(0);
    check(16'({mode, led_auto}), 16'h0009, "auto sel");
    tap(1);
    check(16'({mode, loss_default}), 16'h0011, "auto up");
    tap(0);
    check(16'(mode), 16'h0000, "wrap");
    cmd_type = 3'h2;
    // Each press in close or open stores the live position, so let every seek finish first
    tap(0);
    tick(1000);
    cs = position;
    tap(0);
    check(16'(closed_sp), 16'(cs), "closed restore");
    tick(1000);
    os = position;
    tap(0);
    check(16'(open_sp), 16'(os), "open restore");
    check(16'(mode), 16'h0004, "skip loss");
  endtask
  task t_auto;
    cmd_level = 10'h000;
    tick(1000);
    near(position, tgt(10'h000), "cmd min");
    cmd_level = 10'h3FF;
    tick(1000);
    near(position, tgt(10'h3FF), "cmd max");
    cmd_level = 10'h200;
    tick(1000);
    near(position, tgt(10'h200), "cmd mid");
    comm_active = 1'b1;
    tick(1000);
    near(position, tgt(10'h000), "comm");
    // Flash half-period far exceeds the run, so the flash shows dark here
    check(16'(led_auto), 16'h0000, "comm led");
    comm_active = 1'b0;
    cmd_level = 10'h000;
    tick(1000);
    check(16'(led_auto), 16'h0001, "auto led steady");
  endtask
  task t_trip;
    ovr_ohms = 14'h07D0;
    tick(5);
    current_trip = 1'b1;
    tick(1);
    current_trip = 1'b0;
    tick(4);
    drive(2'h0, "open tripped");
    ovr_ohms = 14'h04B0;
    tick(30);
    drive(2'h1, "close clears");
    ovr_ohms = 14'h07D0;
    tick(5);
    drive(2'h2, "trip cleared");
    current_trip = 1'b1;
    tick(1);
    current_trip = 1'b0;
    ovr_ohms = 14'h04B0;
    tick(5);
    drive(2'h1, "close after trip");
    current_trip = 1'b1;
    tick(1);
    current_trip = 1'b0;
    tick(4);
    drive(2'h0, "close tripped");
    ovr_ohms = 14'h07D0;
    tick(5);
    drive(2'h0, "both blocked");
    ovr_ohms = 14'h0000;
    tap(0);
    check(16'(mode), 16'h0000, "manual for clear");
    tap(1);
    ovr_ohms = 14'h04B0;
    tick(5);
    drive(2'h1, "double cleared");
  endtask
  task t_fault;
    fb_fault = 1'b1;
    ovr_ohms = 14'h07D0;
    tick(45);
    drive(2'h2, "fault run");
    tick(20);
    drive(2'h0, "fault timeout");
    ovr_ohms = 14'h1194;
    tick(5);
    ovr_ohms = 14'h07D0;
    tick(5);
    drive(2'h2, "fault retry");
    ovr_ohms = 14'h01FE;
    tick(5);
    drive(2'h0, "fault stop");
    fb_fault = 1'b0;
    ovr_ohms = 14'h0000;
    tick(5);
  endtask
  task t_override;
    ovr_ohms = 14'h07D0;
    tick(4);
    check(16'({override_on, led_manual}), 16'h0003, "override");
    drive(2'h2, "ovr open");
    tap(0);
    check(16'(mode), 16'h0004, "mode locked");
    tick(1000);
    near(position, os, "open reached");
    drive(2'h0, "open stop");
    ovr_ohms = 14'h04B0;
    tick(5);
    drive(2'h1, "ovr close");
    ovr_ohms = 14'h0CE4;
    tick(20);
    drive(2'h1, "latched");
    ovr_ohms = 14'h01FE;
    tick(5);
    drive(2'h0, "stop");
    ovr_ohms = 14'h0CE4;
    tick(5);
    drive(2'h0, "unlatched");
    ovr_ohms = 14'h04B0;
    tick(5);
    stall = 1'b1;
    tick(1);
    stall = 1'b0;
    tick(10);
    drive(2'h0, "stall lock");
    ovr_ohms = 14'h1194;
    tick(5);
    ovr_ohms = 14'h04B0;
    tick(5);
    drive(2'h1, "retry");
    ovr_ohms = 14'h0000;
    tick(5);
    check(16'({override_on, mode}), 16'h0004, "resume");
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      summarize;
    end
  end
  initial begin
    resetn = 1'b0;
    btn_mode = 1'b0;
    btn_up = 1'b0;
    btn_down = 1'b0;
    stall = 1'b0;
    fb_fault = 1'b0;
    current_trip = 1'b0;
    ovr_ohms = 14'h0000;
    cmd_type = 3'h0;
    cmd_level = 10'h3FF;
    comm_active = 1'b0;
    comm_level = 10'h000;
    tick(5);
    resetn = 1'b1;
    tick(2);
    t_reset;
    t_manual;
    t_setup;
    t_auto;
    t_override;
    t_trip;
    t_fault;
    summarize;
  end
endmodule
`default_nettype wire
